// file: irq_rom_consts.svh
// Constants for the interrupt mask, dropped-frame tally and ROM/LED port.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef IRQ_ROM_CONSTS_SVH
`define IRQ_ROM_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_MASK          8'h00
`define OFS_TALLY         8'h04
`define OFS_ROM           8'h08
`define OFS_ANEG          8'h0c

// ****************************************
// Reset values
// ****************************************
`define MASK_RST          32'h0000_0000
`define TALLY_RST         16'h0000
`define ROM_RST           32'h0000_0000

// ****************************************
// Interrupt mask fields and status groups
// ****************************************
`define NORMAL_SUM_BIT    16
`define ABNORMAL_SUM_BIT  15
`define ANEG_BIT          4
`define NORMAL_GROUP      32'h0000_0045
`define ABNORMAL_GROUP    32'h0000_2baa
`define DIRECT_GROUP      32'h1800_5410

// ****************************************
// Dropped-frame tally fields
// ****************************************
`define TALLY_WRAP_BIT    16

// ****************************************
// ROM access and lamp select fields
// ****************************************
`define LAMP_PICK_HI      31
`define LAMP_PICK_LO      28
`define COMBINE_HI        26
`define COMBINE_LO        25
`define LAMP4_BIT         24
`define ROM_RD_BIT        14
`define ROM_RELOAD_BIT    13
`define BOOT_PICK_BIT     12
`define SERIAL_PICK_BIT   11
`define EE_FROM_CHIP_BIT  3
`define EE_TO_CHIP_BIT    2
`define EE_CLK_BIT        1
`define EE_SELECT_BIT     0

`endif

// file: irq_rom_pkg.sv
// Types for the interrupt mask, dropped-frame tally and ROM/LED port.
// Assumes no other package; users write irq_rom_pkg::name.
package irq_rom_pkg;

    // ****************************************
    // Whole state of the top module
    // ****************************************
    typedef struct packed {
        logic [31:0] mask;
        logic [15:0] tally;
        logic        wrapped;
        logic        aneg;
        logic [3:0]  lamp_pick;
        logic [1:0]  combine;
        logic        lamp4_pick;
        logic        rd_bit;
        logic        reload_bit;
        logic        boot_pick;
        logic        serial_pick;
        logic [7:0]  data;
        logic [1:0]  sdo_sync;
        logic [7:0]  boot_s1;
        logic [7:0]  boot_s2;
        logic [31:0] rdata;
        logic        irq;
        logic [4:0]  led;
        logic        wake;
        logic        ee_cs;
        logic        ee_clk;
        logic        ee_di;
        logic        rom_rd;
        logic        rom_wr;
        logic        reload;
    } port_state_t;

endpackage : irq_rom_pkg

// file: irq_mask_gate.sv
// Combinational gating of interrupt status bits by the enable mask.
// Assumes status and mask come from logic on the same clock.
`timescale 1ns/1ns
`include "irq_rom_consts.svh"

module irq_mask_gate (
    input  wire logic [31:0] status_i,
    input  wire logic [31:0] mask_i,
    output logic      [31:0] pending_o
);

    // Summary enable spread over its group
    function automatic logic [31:0] group_en(input logic [31:0] grp, input logic en);
        group_en = grp & {32{en}};
    endfunction : group_en

    // Abnormal bits need their own enable and the abnormal summary
    // Normal bits need their own enable and the normal summary
    // Direct bits need only their own enable
    assign pending_o = status_i & mask_i &
                       (group_en(`NORMAL_GROUP, mask_i[`NORMAL_SUM_BIT])     // RQ3 RQ6
                      | group_en(`ABNORMAL_GROUP, mask_i[`ABNORMAL_SUM_BIT]) // RQ4 RQ5
                      | `DIRECT_GROUP);                                      // RQ1 RQ2 RQ7 RQ8

endmodule : irq_mask_gate

// file: lamp_wake_mux.sv
// Lamp function selection and wake-up channel combining.
// Assumes all sources are on the same clock; results are registered by the user.
`timescale 1ns/1ns

module lamp_wake_mux (
    input  wire logic [3:0] lamp_pick_i,
    input  wire logic       lamp4_pick_i,
    input  wire logic       act_i,
    input  wire logic       link_i,
    input  wire logic       speed_i,
    input  wire logic       col_i,
    input  wire logic       rx_i,
    input  wire logic       duplex_i,
    input  wire logic       pme_i,
    input  wire logic       combine_en_i,
    input  wire logic [1:0] combine_i,
    input  wire logic [3:0] wake_ch_i,
    output logic      [4:0] led_o,
    output logic            wake_o
);

    // Lamp sources; zero in each select is the reset choice
    assign led_o[0] = lamp_pick_i[0] ? speed_i : act_i;                 // RQ13
    assign led_o[1] = lamp_pick_i[1] ? (link_i & act_i) : link_i;       // RQ13
    assign led_o[2] = lamp_pick_i[2] ? col_i : speed_i;                 // RQ13
    assign led_o[3] = lamp_pick_i[3] ? duplex_i : rx_i;                 // RQ13
    assign led_o[4] = lamp4_pick_i ? pme_i : col_i;                     // RQ14

    // Wake-up channel combination
    always_comb begin
        if (!combine_en_i) begin
            wake_o = |wake_ch_i;                                        // RQ15
        end else begin
            unique case (combine_i)
                2'h0: wake_o = (&wake_ch_i[1:0]) | (&wake_ch_i[3:2]);   // RQ15
                2'h1: wake_o = (&wake_ch_i[1:0]) | wake_ch_i[2] | wake_ch_i[3];
                2'h2: wake_o = (&wake_ch_i[2:0]) | wake_ch_i[3];
                2'h3: wake_o = &wake_ch_i;
            endcase
        end
    end

endmodule : lamp_wake_mux

// file: irq_mask_missed_count_rom_port.sv
// Interrupt enable mask, dropped-frame tally and ROM access / lamp select registers.
// Assumes status, event and lamp sources on clk_i; EEPROM and boot ROM data from pins.
//
// Summary of operation
// RQ1 - Wake-up status interrupts only while mask bit 28 is set.
// RQ2 - Link-changed status interrupts only while mask bit 27 is set.
// RQ3 - Mask bit 16 is the normal summary gating status bits 0, 2, 6.
// RQ4 - Mask bit 15 is the abnormal summary gating bits 1,3,5,7,8,9,11,13.
// RQ5 - Abnormal bits need their own enable and the abnormal summary.
// RQ6 - Normal bits need their own enable and the normal summary.
// RQ7 - Link-fail and early-transmit bits are enabled directly by their mask bits.
// RQ8 - Autonegotiation done sets status bit 4, gated by mask bit 4.
// RQ9 - Interrupt request is high in the cycle after any enabled status bit is set.
// RQ10 - Tally counts frames dropped for lack of a receive descriptor.
// RQ11 - Tally overflow sets the wrap flag; a read of the tally clears it.
// RQ12 - A read of the tally also clears the count.
// RQ13 - Lamp select bits 31..28 reset to zero and pick lamp functions.
// RQ14 - Fifth lamp shows collision, or the power event when bit 24 is set.
// RQ15 - Wake-up channels are combined as the combine bits select.
// RQ16 - Read bit alone reads; read plus reload in serial mode reloads.
// RQ17 - Boot ROM pick acts only without serial pick; low byte carries ROM data.
// RQ18 - Serial pick routes EEPROM access through the low nibble.
// RQ19 - Low nibble: data from EEPROM, data to EEPROM, clock, select.
// RQ20 - Software never sets serial and boot ROM picks together.
`timescale 1ns/1ns
`include "irq_rom_consts.svh"

module irq_mask_missed_count_rom_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Status and events
    input  wire logic [31:0] status_i,
    input  wire logic        aneg_done_i,
    input  wire logic        frame_missed_i,
    output logic             irq_o,
    // Lamps and wake-up
    input  wire logic        act_i,
    input  wire logic        link_i,
    input  wire logic        speed_i,
    input  wire logic        col_i,
    input  wire logic        rx_i,
    input  wire logic        duplex_i,
    input  wire logic        pme_i,
    input  wire logic        combine_en_i,
    input  wire logic [3:0]  wake_ch_i,
    output logic      [4:0]  led_o,
    output logic             wake_o,
    // Serial EEPROM pins
    input  wire logic        ee_from_chip_i,
    output logic             ee_to_chip_o,
    output logic             ee_clk_o,
    output logic             ee_select_o,
    output logic             ee_reload_o,
    // Boot ROM pins
    input  wire logic [7:0]  boot_data_i,
    output logic      [7:0]  boot_wdata_o,
    output logic             boot_rd_o,
    output logic             boot_wr_o
);

    irq_rom_pkg::port_state_t st;
    irq_rom_pkg::port_state_t next_st;

    logic [31:0] status_view;
    logic [31:0] pending;
    logic [4:0]  led_sel;
    logic        wake_sel;

    // ****************************************
    // Interrupt gating and lamp/wake selection
    // ****************************************

    // Bit 4 of the status seen by the gate is the local autonegotiation flag
    always_comb begin
        status_view = status_i;
        status_view[`ANEG_BIT] = st.aneg;                               // RQ8
    end

    irq_mask_gate u_gate (
        .status_i  (status_view),
        .mask_i    (st.mask),
        .pending_o (pending)
    );

    lamp_wake_mux u_lamp (
        .lamp_pick_i  (st.lamp_pick),
        .lamp4_pick_i (st.lamp4_pick),
        .act_i        (act_i),
        .link_i       (link_i),
        .speed_i      (speed_i),
        .col_i        (col_i),
        .rx_i         (rx_i),
        .duplex_i     (duplex_i),
        .pme_i        (pme_i),
        .combine_en_i (combine_en_i),
        .combine_i    (st.combine),
        .wake_ch_i    (wake_ch_i),
        .led_o        (led_sel),
        .wake_o       (wake_sel)
    );

    // ****************************************
    // Register decode
    // ****************************************

    logic wr_mask;
    logic wr_rom;
    logic wr_aneg;
    logic rd_tally;

    assign wr_mask  = wr_i && (addr_i == `OFS_MASK);
    assign wr_rom   = wr_i && (addr_i == `OFS_ROM);
    assign wr_aneg  = wr_i && (addr_i == `OFS_ANEG);
    assign rd_tally = rd_i && (addr_i == `OFS_TALLY);

    // Readback image of the ROM register; in serial mode bit 3 shows the synchronised EEPROM data
    function automatic logic [31:0] rom_image(input irq_rom_pkg::port_state_t s);
        logic [7:0] low;
        low = s.data;
        if (s.serial_pick) begin
            low[`EE_FROM_CHIP_BIT] = s.sdo_sync[1];                     // RQ18 RQ19
        end
        rom_image = {s.lamp_pick, 1'b0, s.combine, s.lamp4_pick, 9'h000,
                     s.rd_bit, s.reload_bit, s.boot_pick, s.serial_pick, 3'h0, low};
    endfunction : rom_image

    // ****************************************
    // Next-state logic
    // ****************************************

    // All state moves together; commands are one-cycle pulses
    always_comb begin
        logic [16:0] bumped;
        logic [15:0] tally_base;
        logic        wrap_base;
        bumped     = 17'h00000;
        tally_base = 16'h0000;
        wrap_base  = 1'b0;
        next_st = st;
        next_st.rom_rd = 1'b0;
        next_st.rom_wr = 1'b0;
        next_st.reload = 1'b0;

        // Two-stage synchronisers for pin inputs
        next_st.sdo_sync = {st.sdo_sync[0], ee_from_chip_i};
        next_st.boot_s1  = boot_data_i;
        next_st.boot_s2  = st.boot_s1;

        // Mask register write
        if (wr_mask) begin
            next_st.mask = wdata_i;
        end

        // Autonegotiation flag: set wins over write-one-to-clear
        if (wr_aneg && wdata_i[`ANEG_BIT]) begin
            next_st.aneg = 1'b0;
        end
        if (aneg_done_i) begin
            next_st.aneg = 1'b1;                                        // RQ8
        end

        // Tally: a read clears, a dropped frame in the same cycle still counts
        tally_base = rd_tally ? `TALLY_RST : st.tally;                  // RQ12
        wrap_base  = rd_tally ? 1'b0 : st.wrapped;                      // RQ11
        next_st.tally   = tally_base;
        next_st.wrapped = wrap_base;
        if (frame_missed_i) begin
            bumped = {1'b0, tally_base} + 17'h00001;
            next_st.tally   = bumped[15:0];                             // RQ10
            next_st.wrapped = wrap_base | bumped[16];                   // RQ11
        end

        // ROM access and lamp select register write
        if (wr_rom) begin
            next_st.lamp_pick   = wdata_i[`LAMP_PICK_HI:`LAMP_PICK_LO]; // RQ13
            next_st.combine     = wdata_i[`COMBINE_HI:`COMBINE_LO];     // RQ15
            next_st.lamp4_pick  = wdata_i[`LAMP4_BIT];                  // RQ14
            next_st.rd_bit      = wdata_i[`ROM_RD_BIT];
            next_st.reload_bit  = wdata_i[`ROM_RELOAD_BIT];
            next_st.boot_pick   = wdata_i[`BOOT_PICK_BIT];
            next_st.serial_pick = wdata_i[`SERIAL_PICK_BIT];
            next_st.data        = wdata_i[7:0];
            if (wdata_i[`ROM_RD_BIT] && !wdata_i[`ROM_RELOAD_BIT]) begin
                next_st.rom_rd = 1'b1;                                  // RQ16
                // Boot ROM read captures the byte on the pins
                if (wdata_i[`BOOT_PICK_BIT] && !wdata_i[`SERIAL_PICK_BIT]) begin
                    next_st.data = st.boot_s2;                          // RQ17 RQ20
                end
            end
            if (wdata_i[`ROM_RD_BIT] && wdata_i[`ROM_RELOAD_BIT] && wdata_i[`SERIAL_PICK_BIT]) begin
                next_st.reload = 1'b1;                                  // RQ16
            end
            if (!wdata_i[`ROM_RD_BIT] && wdata_i[`BOOT_PICK_BIT] && !wdata_i[`SERIAL_PICK_BIT]) begin
                next_st.rom_wr = 1'b1;                                  // RQ17
            end
        end

        // EEPROM pins follow the low nibble only in serial mode
        next_st.ee_cs  = next_st.serial_pick & next_st.data[`EE_SELECT_BIT];  // RQ18 RQ19
        next_st.ee_clk = next_st.serial_pick & next_st.data[`EE_CLK_BIT];     // RQ19
        next_st.ee_di  = next_st.serial_pick & next_st.data[`EE_TO_CHIP_BIT]; // RQ19

        // Registered outputs
        next_st.irq  = |pending;                                        // RQ9
        next_st.led  = led_sel;
        next_st.wake = wake_sel;

        // Read data stands in the cycle after the strobe; unmapped reads zero
        next_st.rdata = 32'h0000_0000;
        if (rd_i) begin
            unique case (addr_i)
                `OFS_MASK:  next_st.rdata = st.mask;
                `OFS_TALLY: next_st.rdata = {15'h0000, st.wrapped, st.tally};
                `OFS_ROM:   next_st.rdata = rom_image(st);
                `OFS_ANEG:  next_st.rdata = {27'h0000000, st.aneg, 4'h0};
                default:    next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Boot ROM write data drives from the low byte in every mode
    assign rdata_o      = st.rdata;
    assign irq_o        = st.irq;
    assign led_o        = st.led;
    assign wake_o       = st.wake;
    assign ee_to_chip_o = st.ee_di;
    assign ee_clk_o     = st.ee_clk;
    assign ee_select_o  = st.ee_cs;
    assign ee_reload_o  = st.reload;
    assign boot_wdata_o = st.data;
    assign boot_rd_o    = st.rom_rd;
    assign boot_wr_o    = st.rom_wr;

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_wake_irq;
        status_i[28] && st.mask[28] |=> irq_o;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("wake event enabled but no irq"); // RQ1

    property p_link_masked;
        (status_i == 32'h0800_0000) && !st.aneg && !st.mask[27] |=> !irq_o;
    endproperty
    a_link_masked: assert property (p_link_masked) else $error("masked link change raised irq"); // RQ2

    property p_normal_sum;
        (status_i == 32'h0000_0001) && !st.aneg && st.mask[0] && !st.mask[16] |=> !irq_o;
    endproperty
    a_normal_sum: assert property (p_normal_sum) else $error("normal bit passed without summary"); // RQ3 RQ6

    property p_abnormal;
        status_i[13] && st.mask[13] && st.mask[15] |=> irq_o;
    endproperty
    a_abnormal: assert property (p_abnormal) else $error("abnormal bit enabled but no irq"); // RQ4 RQ5

    property p_direct;
        status_i[12] && st.mask[12] && !st.mask[15] && !st.mask[16] |=> irq_o;
    endproperty
    a_direct: assert property (p_direct) else $error("link fail enable did not act directly"); // RQ7

    property p_aneg;
        aneg_done_i |=> st.aneg;
    endproperty
    a_aneg: assert property (p_aneg) else $error("autonegotiation flag not set"); // RQ8

    property p_irq_drop;
        (pending == 32'h0000_0000) |=> !irq_o;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq held with nothing pending"); // RQ9

    property p_count;
        frame_missed_i && !rd_tally && (st.tally != 16'hffff) |=> st.tally == $past(st.tally) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("tally did not count a dropped frame"); // RQ10

    property p_wrap;
        frame_missed_i && !rd_tally && (st.tally == 16'hffff) |=> st.wrapped && (st.tally == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("tally overflow not flagged"); // RQ11

    property p_read_clear;
        rd_tally && !frame_missed_i |=> (st.tally == 16'h0000) && !st.wrapped
                                        && (rdata_o[16:0] == {$past(st.wrapped), $past(st.tally)});
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("tally read did not clear"); // RQ11 RQ12

    property p_lamp4;
        !st.lamp4_pick ##1 !st.lamp4_pick |-> led_o[4] == $past(col_i);
    endproperty
    a_lamp4: assert property (p_lamp4) else $error("fifth lamp not showing collision"); // RQ14

    property p_serial_off;
        !st.serial_pick |-> !ee_select_o && !ee_clk_o && !ee_to_chip_o;
    endproperty
    a_serial_off: assert property (p_serial_off) else $error("EEPROM pins driven outside serial mode"); // RQ18

    property p_reload;
        wr_rom && wdata_i[14] && wdata_i[13] && wdata_i[11] |=> ee_reload_o && !boot_rd_o;
    endproperty
    a_reload: assert property (p_reload) else $error("reload command not issued"); // RQ16

    c_overflow: cover property (frame_missed_i && st.tally == 16'hffff);
    c_reload:   cover property (ee_reload_o);
    c_irq_rise: cover property (!irq_o ##1 irq_o);
    c_boot_rd:  cover property (boot_rd_o && st.boot_pick);

endmodule : irq_mask_missed_count_rom_port

// file: rom_partner.sv
// Serial EEPROM and parallel boot ROM standing at the far side of the port.
// Assumes the EEPROM select and clock come straight from the block; the boot ROM data goes straight to it.
`timescale 1ns/1ns

module rom_partner #(
    parameter logic [15:0] WORD = 16'hc3a5,
    parameter logic [7:0]  BOOT = 8'h3c
) (
    input  wire logic       ee_select_i,
    input  wire logic       ee_clk_i,
    output logic            ee_data_o,
    output logic      [7:0] boot_data_o
);
    // ****************************************
    // EEPROM bit stream
    // ****************************************
    logic [3:0] idx  = 4'h0;
    logic       held = 1'b0;

    // Next bit on each serial clock while selected; deselect restarts the word
    // One process owns idx, so the two events cannot race as two drivers
    always @(posedge ee_clk_i or negedge ee_select_i) begin
        if (ee_select_i) begin
            idx <= idx + 4'h1;
        end else begin
            held <= WORD[idx];
            idx  <= 4'h0;
        end
    end

    // Released pin shows the inverse so a stale value cannot pass as data
    assign ee_data_o   = ee_select_i ? WORD[idx] : ~held;
    // Boot ROM output enable is tied on, so the byte is always present
    assign boot_data_o = BOOT;
endmodule : rom_partner

// file: irq_mask_missed_count_rom_port_bench.sv
// Self-checking bench for the mask, tally and ROM/lamp register block.
// Assumes rom_partner on the EEPROM and boot ROM pins; one 100 MHz clock.
`timescale 1ns/1ns

module irq_mask_missed_count_rom_port_bench;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00, boot_data, boot_wdata_o;
    logic [31:0] wdata_i = 32'h0, status_i = 32'h0, rdata_o, d;
    logic        aneg_done_i = 1'b0, frame_missed_i = 1'b0, combine_en_i = 1'b0;
    logic [6:0]  src = 7'h00;
    logic [3:0]  wake_ch_i = 4'h0;
    logic [4:0]  led_o;
    logic        irq_o, wake_o, ee_data, ee_to_chip_o, ee_clk_o, ee_select_o;
    logic        ee_reload_o, boot_rd_o, boot_wr_o;
    int          err_total = 0, n_compared = 0;

    always #5 clk_i = ~clk_i;

    irq_mask_missed_count_rom_port uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .status_i(status_i),
        .aneg_done_i(aneg_done_i), .frame_missed_i(frame_missed_i), .irq_o(irq_o),
        .act_i(src[0]), .link_i(src[1]), .speed_i(src[2]), .col_i(src[3]), .rx_i(src[4]),
        .duplex_i(src[5]), .pme_i(src[6]), .combine_en_i(combine_en_i), .wake_ch_i(wake_ch_i),
        .led_o(led_o), .wake_o(wake_o), .ee_from_chip_i(ee_data), .ee_to_chip_o(ee_to_chip_o),
        .ee_clk_o(ee_clk_o), .ee_select_o(ee_select_o), .ee_reload_o(ee_reload_o),
        .boot_data_i(boot_data), .boot_wdata_o(boot_wdata_o), .boot_rd_o(boot_rd_o),
        .boot_wr_o(boot_wr_o));

    rom_partner peer (.ee_select_i(ee_select_o), .ee_clk_i(ee_clk_o), .ee_data_o(ee_data),
        .boot_data_o(boot_data));

    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // One-cycle strobes; returns just after the sampling edge
    task bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
        @(posedge clk_i) wr_i <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_i) rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : bus_rd

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    function automatic logic [4:0] lamp_exp(logic [4:0] p, logic [6:0] s);
        lamp_exp = {p[4] ? s[6] : s[3], p[3] ? s[5] : s[4], p[2] ? s[3] : s[2],
                    p[1] ? s[1] & s[0] : s[1], p[0] ? s[2] : s[0]};
    endfunction : lamp_exp

    function automatic logic wake_exp(logic en, logic [1:0] c, logic [3:0] w);
        case ({en, c})
            3'b100: wake_exp = (w[0] & w[1]) | (w[2] & w[3]);
            3'b101: wake_exp = (w[0] & w[1]) | w[2] | w[3];
            3'b110: wake_exp = (w[0] & w[1] & w[2]) | w[3];
            3'b111: wake_exp = &w;
            default: wake_exp = |w;
        endcase
    endfunction : wake_exp

    // ****************************************
    // Scenarios
    // ****************************************
    task t_mask;
        logic [31:0] nrm, abn, m [3];
        logic        e;
        nrm = 32'h45;
        abn = 32'h2baa;
        for (int b = 0; b < 29; b++) begin
            if (b == 4 || (b > 14 && b < 27))
                continue;
            m = '{32'h1 << b, 32'h18000, (32'h1 << b) | 32'h18000};
            for (int k = 0; k < 3; k++) begin
                @(posedge clk_i) status_i <= 32'h1 << b;
                bus_wr(8'h00, m[k]);
                settle(2);
                e = m[k][b] & (nrm[b] ? m[k][16] : (abn[b] ? m[k][15] : 1'b1));
                chk("irq gate", {31'h0, irq_o}, {31'h0, e});
            end
        end
        @(posedge clk_i) status_i <= 32'h0;
        settle(2);
        chk("irq idle", {31'h0, irq_o}, 32'h0);
    endtask : t_mask

    // Autonegotiation flag stays set while masked, then raises the request
    task t_aneg;
        bus_wr(8'h00, 32'h0);
        @(posedge clk_i) aneg_done_i <= 1'b1;
        @(posedge clk_i) aneg_done_i <= 1'b0;
        settle(2);
        chk("aneg masked", {31'h0, irq_o}, 32'h0);
        bus_wr(8'h00, 32'h10);
        settle(2);
        chk("aneg irq", {31'h0, irq_o}, 32'h1);
        bus_wr(8'h0c, 32'h10);
        settle(2);
        chk("aneg cleared", {31'h0, irq_o}, 32'h0);
    endtask : t_aneg

    task t_tally(input int n, input logic [31:0] e);
        @(posedge clk_i) frame_missed_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        frame_missed_i <= 1'b0;
        bus_rd(8'h04, d);
        chk("tally", d, e);
        bus_rd(8'h04, d);
        chk("tally after read", d, 32'h0);
    endtask : t_tally

    task t_lamp;
        logic [31:0] w [3];
        logic [4:0]  p [3];
        w = '{32'h0, 32'hf100_0000, 32'h5000_0000};
        p = '{5'h00, 5'h1f, 5'h05};
        for (int k = 0; k < 3; k++) begin
            bus_wr(8'h08, w[k]);
            for (int s = 0; s < 128; s++) begin
                @(posedge clk_i) src <= s[6:0];
                settle(1);
                chk("lamps", {27'h0, led_o}, {27'h0, lamp_exp(p[k], s[6:0])});
            end
        end
    endtask : t_lamp

    task t_wake;
        for (int c = 0; c < 8; c++) begin
            bus_wr(8'h08, {5'h0, c[1:0], 25'h0});
            for (int x = 0; x < 16; x++) begin
                @(posedge clk_i) {combine_en_i, wake_ch_i} <= {c[2], x[3:0]};
                settle(1);
                chk("wake", {31'h0, wake_o}, {31'h0, wake_exp(c[2], c[1:0], x[3:0])});
            end
        end
    endtask : t_wake

    // Only one of serial and boot pick is ever written at a time
    task t_rom;
        bus_wr(8'h08, 32'h5000);
        #1 chk("boot read", {31'h0, boot_rd_o}, 32'h1);
        bus_rd(8'h08, d);
        chk("boot byte", d, 32'h503c);
        bus_wr(8'h08, 32'h10a5);
        #1 chk("boot write", {23'h0, boot_wr_o, boot_wdata_o}, 32'h1a5);
        bus_wr(8'h08, 32'h6800);
        #1 chk("reload", {30'h0, ee_reload_o, boot_rd_o}, 32'h2);
        bus_wr(8'h08, 32'h0801);
        #1 chk("ee pins", {29'h0, ee_to_chip_o, ee_clk_o, ee_select_o}, 32'h1);
        settle(3);
        bus_rd(8'h08, d);
        chk("ee bit0", d, 32'h0809);
        bus_wr(8'h08, 32'h0807);
        #1 chk("ee clk", {29'h0, ee_to_chip_o, ee_clk_o, ee_select_o}, 32'h7);
        bus_wr(8'h08, 32'h0805);
        settle(3);
        bus_rd(8'h08, d);
        chk("ee bit1", d, 32'h0805);
        bus_wr(8'h08, 32'h0007);
        #1 chk("ee off", {29'h0, ee_to_chip_o, ee_clk_o, ee_select_o}, 32'h0);
    endtask : t_rom

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 20; a += 4) begin
            bus_rd(a[7:0], d);
            chk("reset value", d, 32'h0);
        end
        t_mask();
        t_aneg();
        t_tally(3, 32'h3);
        t_tally(65537, 32'h10001);
        t_lamp();
        t_wake();
        t_rom();
        final_report();
    end

    // Hang guard beyond the planned run of about 67k cycles, below 100k cycles
    initial begin
        #900000;
        err_total++;
        final_report();
    end
endmodule : irq_mask_missed_count_rom_port_bench
